// ==== verilog/srrc_defines.svh ====
`ifndef SRRC_DEFINES_SVH
`define SRRC_DEFINES_SVH

// ==========================================================
// register map (byte addresses)
`define SRRC_ADDR_CTRL 12'h000
`define SRRC_ADDR_INSTR 12'h004
`define SRRC_ADDR_STAT 12'h008
`define SRRC_ADDR_WREG 12'h00c
`define SRRC_ADDR_FLAGS 12'h010
`define SRRC_ADDR_BSR 12'h014
`define SRRC_ADDR_WSHD 12'h018
`define SRRC_ADDR_FSHD 12'h01c
`define SRRC_ADDR_BSHD 12'h020
`define SRRC_ADDR_PC 12'h024
`define SRRC_ADDR_LATU 12'h028
`define SRRC_ADDR_LATH 12'h02c
`define SRRC_ADDR_STACK 12'h030
`define SRRC_ADDR_IDXB 12'h034
`define SRRC_ADDR_FADDR 12'h038
`define SRRC_ADDR_FDATA 12'h03c

// ==========================================================
// widths
`define SRRC_PC_W 21
`define SRRC_FA_W 12
`define SRRC_IW 16

// ==========================================================
// field positions
`define SRRC_CTRL_EXT 0
`define SRRC_STAT_BUSY 0
`define SRRC_STAT_BAD 1
`define SRRC_RET_S 0
`define SRRC_RLC_D 9
`define SRRC_RLC_A 8
`define SRRC_FLAG_C 0
`define SRRC_FLAG_Z 2
`define SRRC_FLAG_N 4

// ==========================================================
// opcodes and addressing constants
`define SRRC_OP_RET 16'h0012
`define SRRC_OP_RET_MASK 16'hfffe
`define SRRC_OP_RLC 16'h3400
`define SRRC_OP_RLC_MASK 16'hfc00
`define SRRC_ACC_LIMIT 8'h5f
`define SRRC_ACC_LO_BANK 4'h0
`define SRRC_ACC_HI_BANK 4'hf
`define SRRC_RST_BYTE 8'h00

`endif

// ==== verilog/srrc_pkg.sv ====
package srrc_pkg;

	// four phases of one instruction cycle
	typedef enum logic [1:0] {
		SRRC_Q1 = 2'b00,
		SRRC_Q2 = 2'b01,
		SRRC_Q3 = 2'b10,
		SRRC_Q4 = 2'b11
	} srrc_phase_t;

	typedef enum logic [1:0] {
		SRRC_IDLE = 2'b00,
		SRRC_RET = 2'b01,
		SRRC_RET_NOP = 2'b10,
		SRRC_RLC = 2'b11
	} srrc_state_t;

endpackage

// ==== verilog/srrc_return_stack.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "srrc_defines.svh"

module srrc_return_stack #(
	parameter int DEPTH = 31
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic push,
	input wire logic [`SRRC_PC_W-1:0] push_data,
	input wire logic pop,
	output logic [`SRRC_PC_W-1:0] stack_top_entry
);
	localparam int PW = $clog2(DEPTH + 1);

	if (DEPTH < 1 || DEPTH > 255) begin : g_bad_depth
		$error("return stack depth out of range");
	end

	logic [`SRRC_PC_W-1:0] mem_r [DEPTH];
	logic [PW-1:0] lvl_r;

	wire full = (lvl_r == PW'(DEPTH));
	wire empty = (lvl_r == '0);
	wire [PW-1:0] top_idx = lvl_r - PW'(1);

	// an empty stack reads as zero; an overflowing push is dropped
	assign stack_top_entry = empty ? '0 : mem_r[top_idx];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_r <= '0;
		end else if (push && !full) begin
			lvl_r <= lvl_r + PW'(1);
		end else if (pop && !empty) begin
			lvl_r <= top_idx;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= '0;
			end
		end else if (push && !full) begin
			mem_r[lvl_r] <= push_data;
		end
	end

endmodule
`default_nettype wire

// ==== verilog/srrc_rotate_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "srrc_defines.svh"

module srrc_rotate_unit (
	input wire logic [7:0] opnd,
	input wire logic carry_in,
	input wire logic [7:0] file_addr,
	input wire logic access_sel,
	input wire logic ext_en,
	input wire logic [3:0] bank_select_reg,
	input wire logic [`SRRC_FA_W-1:0] idx_base,
	output logic [`SRRC_FA_W-1:0] eff_addr,
	output logic [7:0] result,
	output logic carry_out,
	output logic neg,
	output logic zero
);
	// ==========================================================
	// address resolution
	wire low_half = (file_addr <= `SRRC_ACC_LIMIT);
	wire indexed = !access_sel && ext_en && low_half;
	wire [`SRRC_FA_W-1:0] idx_addr = idx_base + {4'h0, file_addr};
	wire [3:0] acc_bank = low_half ? `SRRC_ACC_LO_BANK : `SRRC_ACC_HI_BANK;

	// indexed literal offset in low half
	assign eff_addr = indexed ? idx_addr :
		access_sel ? {bank_select_reg, file_addr} : {acc_bank, file_addr};

	// ==========================================================
	// rotate left through carry
	// bit n to n+1, bit 7 to carry
	assign result = {opnd[6:0], carry_in};
	assign carry_out = opnd[7];
	assign neg = result[7];
	assign zero = (result == 8'h00);

endmodule
`default_nettype wire

// ==== verilog/srrc_core.sv ====
// How it works
// - A return pops the stack into the counter in its first Q4, idles a cycle, keeps flags unless the shadow bit is set.
// - A return with the shadow bit set reloads working, flags and bank select from shadows.
// - A return with the shadow bit clear leaves working, flags and bank select alone.
// - A return never touches the upper and high counter latches, only the counter.
// - The rotate takes one cycle, shifts left through carry, and sets carry, negative, zero.
// - The rotate writes working when the destination bit is 0 and the file byte when it is 1.
// - The rotate uses the access bank for access bit 0 and the bank-select register for 1.
// - With access bit 0 and extended set on, addresses up to 95 use indexed literal offset.
// - The rotate runs decode, read, process and write in Q1 to Q4.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "srrc_defines.svh"

module srrc_core
	import srrc_pkg::*;
#(
	parameter int STACK_DEPTH = 31,
	parameter int MEM_AW = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	if (MEM_AW < 8 || MEM_AW > `SRRC_FA_W) begin : g_bad_aw
		$error("file memory address width out of range");
	end

	// ==========================================================
	// state
	srrc_phase_t phase_r;
	srrc_state_t state_r, state_nxt;
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r;
	logic ext_en_r, pend_r, bad_r;
	logic [`SRRC_IW-1:0] instr_r;
	logic [7:0] w_r, flags_r, bsr_r, ws_r, fs_r, bs_r, latu_r, lath_r;
	logic [7:0] w_nxt, flags_nxt;
	logic [`SRRC_PC_W-1:0] pc_r;
	logic [`SRRC_FA_W-1:0] idxb_r, faddr_r, ea_r;
	logic [7:0] opnd_r, res_r;
	logic cout_r, neg_r, zero_r;
	logic [7:0] mem_r [2**MEM_AW];

	// ==========================================================
	// bus decode
	wire sel_ctrl = (paddr == `SRRC_ADDR_CTRL);
	wire sel_instr = (paddr == `SRRC_ADDR_INSTR);
	wire sel_stat = (paddr == `SRRC_ADDR_STAT);
	wire sel_w = (paddr == `SRRC_ADDR_WREG);
	wire sel_flags = (paddr == `SRRC_ADDR_FLAGS);
	wire sel_bsr = (paddr == `SRRC_ADDR_BSR);
	wire sel_ws = (paddr == `SRRC_ADDR_WSHD);
	wire sel_fs = (paddr == `SRRC_ADDR_FSHD);
	wire sel_bs = (paddr == `SRRC_ADDR_BSHD);
	wire sel_pc = (paddr == `SRRC_ADDR_PC);
	wire sel_latu = (paddr == `SRRC_ADDR_LATU);
	wire sel_lath = (paddr == `SRRC_ADDR_LATH);
	wire sel_stack = (paddr == `SRRC_ADDR_STACK);
	wire sel_idxb = (paddr == `SRRC_ADDR_IDXB);
	wire sel_faddr = (paddr == `SRRC_ADDR_FADDR);
	wire sel_fdata = (paddr == `SRRC_ADDR_FDATA);
	wire sel_arch = sel_w | sel_flags | sel_bsr | sel_ws | sel_fs | sel_bs | sel_pc |
		sel_latu | sel_lath | sel_stack | sel_idxb | sel_faddr | sel_fdata;
	wire mapped = sel_ctrl | sel_instr | sel_stat | sel_arch;

	wire busy = pend_r | (state_r != SRRC_IDLE);
	wire acc_first = psel & penable & ~pready_r;
	wire xfer = psel & penable & pready_r;
	wire wr_ok = xfer & pwrite & ~pslverr_r;
	// writes that would race the running instruction are refused
	wire err_nxt = ~mapped | (pwrite & busy & (sel_arch | sel_instr));

	wire [MEM_AW-1:0] f_idx = faddr_r[MEM_AW-1:0];
	wire [MEM_AW-1:0] e_idx = ea_r[MEM_AW-1:0];
	wire [`SRRC_PC_W-1:0] stack_top_entry;

	wire [31:0] rd_mux =
		({32{sel_ctrl}} & {31'h0, ext_en_r}) |
		({32{sel_instr}} & {16'h0, instr_r}) |
		({32{sel_stat}} & {30'h0, bad_r, busy}) |
		({32{sel_w}} & {24'h0, w_r}) |
		({32{sel_flags}} & {24'h0, flags_r}) |
		({32{sel_bsr}} & {24'h0, bsr_r}) |
		({32{sel_ws}} & {24'h0, ws_r}) |
		({32{sel_fs}} & {24'h0, fs_r}) |
		({32{sel_bs}} & {24'h0, bs_r}) |
		({32{sel_pc}} & {11'h0, pc_r}) |
		({32{sel_latu}} & {24'h0, latu_r}) |
		({32{sel_lath}} & {24'h0, lath_r}) |
		({32{sel_stack}} & {11'h0, stack_top_entry}) |
		({32{sel_idxb}} & {20'h0, idxb_r}) |
		({32{sel_faddr}} & {20'h0, faddr_r}) |
		({32{sel_fdata}} & {24'h0, mem_r[f_idx]});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= acc_first;
			pslverr_r <= acc_first & err_nxt;
			prdata_r <= (acc_first && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
		end
	end

	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign prdata = prdata_r;

	// ==========================================================
	// instruction decode and sequencing
	wire is_ret = ((instr_r & `SRRC_OP_RET_MASK) == `SRRC_OP_RET);
	wire is_rlc = ((instr_r & `SRRC_OP_RLC_MASK) == `SRRC_OP_RLC);
	wire s_bit = instr_r[`SRRC_RET_S];
	wire d_bit = instr_r[`SRRC_RLC_D];
	wire a_bit = instr_r[`SRRC_RLC_A];
	wire at_q4 = (phase_r == SRRC_Q4);
	wire take = at_q4 & pend_r & (state_r != SRRC_RET);
	wire ret_pop = (state_r == SRRC_RET) & at_q4;
	wire rlc_wr = (state_r == SRRC_RLC) & at_q4;
	wire issue = wr_ok & sel_instr;
	wire bad_set = take & ~is_ret & ~is_rlc;
	wire bad_clr = wr_ok & sel_stat & pwdata[`SRRC_STAT_BAD];

	always_comb begin
		state_nxt = state_r;
		if (at_q4) begin
			unique case (state_r)
				SRRC_RET: state_nxt = SRRC_RET_NOP;
				SRRC_IDLE, SRRC_RET_NOP, SRRC_RLC: begin
					state_nxt = !pend_r ? SRRC_IDLE :
						is_ret ? SRRC_RET : is_rlc ? SRRC_RLC : SRRC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= SRRC_Q1;
			state_r <= SRRC_IDLE;
			pend_r <= 1'b0;
			bad_r <= 1'b0;
		end else begin
			phase_r <= srrc_phase_t'(phase_r + 2'b01);
			state_r <= state_nxt;
			pend_r <= issue | (pend_r & ~take);
			// a new bad opcode wins over a clear
			bad_r <= bad_set | (bad_r & ~bad_clr);
		end
	end

	// ==========================================================
	// rotate datapath
	wire [`SRRC_FA_W-1:0] eff_addr;
	wire [7:0] rot_res;
	wire rot_c, rot_n, rot_z;

	srrc_rotate_unit u_rot (
		.opnd(opnd_r),
		.carry_in(flags_r[`SRRC_FLAG_C]),
		.file_addr(instr_r[7:0]),
		.access_sel(a_bit),
		.ext_en(ext_en_r),
		.bank_select_reg(bsr_r[3:0]),
		.idx_base(idxb_r),
		.eff_addr(eff_addr),
		.result(rot_res),
		.carry_out(rot_c),
		.neg(rot_n),
		.zero(rot_z)
	);

	// Q1 decode, Q2 read, Q3 process
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ea_r <= '0;
			opnd_r <= `SRRC_RST_BYTE;
			res_r <= `SRRC_RST_BYTE;
			cout_r <= 1'b0;
			neg_r <= 1'b0;
			zero_r <= 1'b0;
		end else if (state_r == SRRC_RLC) begin
			if (phase_r == SRRC_Q1) begin
				ea_r <= eff_addr;
			end
			if (phase_r == SRRC_Q2) begin
				opnd_r <= mem_r[e_idx];
			end
			if (phase_r == SRRC_Q3) begin
				res_r <= rot_res;
				cout_r <= rot_c;
				neg_r <= rot_n;
				zero_r <= rot_z;
			end
		end
	end

	// ==========================================================
	// architectural registers
	wire ret_shadow = ret_pop & s_bit;
	wire [7:0] rlc_flags = {flags_r[7:5], neg_r, flags_r[3], zero_r, flags_r[1], cout_r};

	// no update when shadow bit clear
	assign w_nxt = (rlc_wr && !d_bit) ? res_r : ret_shadow ? ws_r :
		(wr_ok && sel_w) ? pwdata[7:0] : w_r;
	assign flags_nxt = rlc_wr ? rlc_flags : ret_shadow ? fs_r :
		(wr_ok && sel_flags) ? pwdata[7:0] : flags_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_en_r <= 1'b0;
			instr_r <= '0;
			w_r <= `SRRC_RST_BYTE;
			flags_r <= `SRRC_RST_BYTE;
			bsr_r <= `SRRC_RST_BYTE;
			ws_r <= `SRRC_RST_BYTE;
			fs_r <= `SRRC_RST_BYTE;
			bs_r <= `SRRC_RST_BYTE;
			latu_r <= `SRRC_RST_BYTE;
			lath_r <= `SRRC_RST_BYTE;
			idxb_r <= '0;
			faddr_r <= '0;
		end else begin
			w_r <= w_nxt;
			flags_r <= flags_nxt;
			if (ret_shadow) begin
				bsr_r <= bs_r;
			end else if (wr_ok && sel_bsr) begin
				bsr_r <= pwdata[7:0];
			end
			if (wr_ok && sel_ctrl) ext_en_r <= pwdata[`SRRC_CTRL_EXT];
			if (issue) instr_r <= pwdata[`SRRC_IW-1:0];
			if (wr_ok && sel_ws) ws_r <= pwdata[7:0];
			if (wr_ok && sel_fs) fs_r <= pwdata[7:0];
			if (wr_ok && sel_bs) bs_r <= pwdata[7:0];
			if (wr_ok && sel_latu) latu_r <= pwdata[7:0];
			if (wr_ok && sel_lath) lath_r <= pwdata[7:0];
			if (wr_ok && sel_idxb) idxb_r <= pwdata[`SRRC_FA_W-1:0];
			if (wr_ok && sel_faddr) faddr_r <= pwdata[`SRRC_FA_W-1:0];
		end
	end

	// pop into the counter at Q4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_r <= '0;
		end else if (ret_pop) begin
			pc_r <= stack_top_entry;
		end else if (wr_ok && sel_pc) begin
			pc_r <= pwdata[`SRRC_PC_W-1:0];
		end
	end

	// destination 1 goes to the file byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 2**MEM_AW; i++) begin
				mem_r[i] <= `SRRC_RST_BYTE;
			end
		end else if (rlc_wr && d_bit) begin
			mem_r[e_idx] <= res_r;
		end else if (wr_ok && sel_fdata) begin
			mem_r[f_idx] <= pwdata[7:0];
		end
	end

	srrc_return_stack #(
		.DEPTH(STACK_DEPTH)
	) u_stack (
		.pclk(pclk),
		.presetn(presetn),
		.push(wr_ok & sel_stack),
		.push_data(pwdata[`SRRC_PC_W-1:0]),
		.pop(ret_pop),
		.stack_top_entry(stack_top_entry)
	);

	// ==========================================================
	// assertions
	wire rlc_q2 = (state_r == SRRC_RLC) && (phase_r == SRRC_Q2);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ret_pop_pc: assert property (ret_pop |=> pc_r == $past(stack_top_entry))
		else $error("return did not load counter from stack");
	a_ret_two_cyc: assert property (ret_pop |=> (state_r == SRRC_RET_NOP) [*4])
		else $error("return second cycle missing");
	a_ret_shadow: assert property (ret_shadow |=>
		w_r == $past(ws_r) && flags_r == $past(fs_r) && bsr_r == $past(bs_r))
		else $error("shadow reload missing");
	a_ret_noshadow: assert property (ret_pop && !s_bit |=>
		$stable(w_r) && $stable(flags_r) && $stable(bsr_r))
		else $error("registers changed without shadow bit");
	a_ret_latches: assert property (state_r inside {SRRC_RET, SRRC_RET_NOP} |=>
		$stable(latu_r) && $stable(lath_r))
		else $error("counter latch changed during return");
	a_rlc_carry: assert property (rlc_wr |=>
		flags_r[`SRRC_FLAG_C] == $past(opnd_r[7]) &&
		flags_r[`SRRC_FLAG_Z] == ($past(res_r) == 8'h00))
		else $error("rotate flags wrong");
	a_rlc_to_w: assert property (rlc_wr && !d_bit |=> w_r == $past(res_r))
		else $error("rotate result not in working");
	a_rlc_to_file: assert property (rlc_wr && d_bit |=>
		$stable(w_r) && mem_r[e_idx] == $past(res_r))
		else $error("rotate result not in file");
	a_rlc_bank: assert property (rlc_q2 && a_bit |-> ea_r == {bsr_r[3:0], instr_r[7:0]})
		else $error("banked address wrong");
	a_rlc_indexed: assert property (rlc_q2 && !a_bit && ext_en_r &&
		instr_r[7:0] <= `SRRC_ACC_LIMIT |-> ea_r == idxb_r + {4'h0, instr_r[7:0]})
		else $error("indexed address wrong");
	a_rlc_process: assert property (state_r == SRRC_RLC && phase_r == SRRC_Q3 |=>
		res_r == {$past(opnd_r[6:0]), $past(flags_r[`SRRC_FLAG_C])})
		else $error("rotate processing wrong");

	c_ret_shadow: cover property (ret_shadow);
	c_rlc_w: cover property (rlc_wr && !d_bit);
	c_rlc_indexed: cover property (state_r == SRRC_RLC && !a_bit && ext_en_r);
	c_bad_op: cover property (bad_set);

endmodule
`default_nettype wire

// ==== sim/test_subroutine_return_and_rotate_carry.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "srrc_defines.svh"

module test_subroutine_return_and_rotate_carry
	import srrc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	int err_count = 0;
	int n_checks = 0;
	logic [31:0] rd;
	logic er;

	srrc_core #(.STACK_DEPTH(31), .MEM_AW(12)) dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr)
	);

	initial begin
		forever #50 pclk = ~pclk;
	end

	// ==========================================================
	// reporting
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	// ==========================================================
	// apb master
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			chk("pready timeout", {31'h0, pready}, 32'h1);
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_ok(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk("write error flag", {31'h0, er}, 32'h0);
	endtask

	task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask

	// wait until the issued instruction has retired
	task automatic settle();
		int n;
		repeat (4) @(posedge pclk);
		n = 0;
		do begin
			apb(1'b0, `SRRC_ADDR_STAT, 32'h0);
			n++;
		end while (rd[`SRRC_STAT_BUSY] !== 1'b0 && n < 40);
		if (rd[`SRRC_STAT_BUSY] !== 1'b0) begin
			chk("busy timeout", {31'h0, rd[`SRRC_STAT_BUSY]}, 32'h0);
			give_verdict();
		end
	endtask

	task automatic run(input logic [15:0] op);
		wr_ok(`SRRC_ADDR_INSTR, {16'h0, op});
		settle();
	endtask

	// ==========================================================
	// main sequence
	initial begin
		logic d;
		logic a;
		logic ext;
		logic [7:0] f;
		logic [7:0] v;
		logic [7:0] res;
		logic [11:0] ea;
		logic [31:0] w;
		logic [31:0] fl;
		logic [31:0] b;
		logic [31:0] ix;
		logic [31:0] ws;
		logic [31:0] fs;
		logic [31:0] bs;
		logic [31:0] lu;
		logic [31:0] lh;
		logic [31:0] p0;
		logic [31:0] p1;
		logic [31:0] stk[$];
		void'($urandom(32'he804));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			rd_chk("reset value", 12'(i * 4), 32'h0);
		end
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped read error", {31'h0, er}, 32'h1);
		chk("unmapped read data", rd, 32'h0);
		apb(1'b1, 12'h040, 32'hffffffff);
		chk("unmapped write error", {31'h0, er}, 32'h1);
		run(16'h0000);
		rd_chk("bad opcode status", `SRRC_ADDR_STAT, 32'h2);
		wr_ok(`SRRC_ADDR_STAT, 32'h2);
		rd_chk("status cleared", `SRRC_ADDR_STAT, 32'h0);
		// rotate through carry over every d, a and extended-set mix
		for (int i = 0; i < 24; i++) begin
			d = i[0];
			a = i[1];
			ext = i[2];
			f = (i % 3 == 0) ? 8'h5f : (i % 3 == 1) ? 8'h60 : 8'($urandom);
			w = $urandom & 32'hff;
			fl = $urandom & 32'h15;
			b = $urandom & 32'hf;
			ix = $urandom & 32'hfff;
			v = 8'($urandom);
			if (a) begin
				ea = {b[3:0], f};
			end else if (ext && f <= 8'h5f) begin
				ea = ix[11:0] + {4'h0, f};
			end else begin
				ea = {(f <= 8'h5f) ? 4'h0 : 4'hf, f};
			end
			wr_ok(`SRRC_ADDR_CTRL, {31'h0, ext});
			wr_ok(`SRRC_ADDR_WREG, w);
			wr_ok(`SRRC_ADDR_FLAGS, fl);
			wr_ok(`SRRC_ADDR_BSR, b);
			wr_ok(`SRRC_ADDR_IDXB, ix);
			wr_ok(`SRRC_ADDR_FADDR, {20'h0, ea});
			wr_ok(`SRRC_ADDR_FDATA, {24'h0, v});
			run(`SRRC_OP_RLC | {6'h0, d, a, f});
			res = {v[6:0], fl[0]};
			rd_chk("rotate working", `SRRC_ADDR_WREG, d ? w : {24'h0, res});
			rd_chk("rotate file byte", `SRRC_ADDR_FDATA, {24'h0, d ? res : v});
			rd_chk("rotate flags", `SRRC_ADDR_FLAGS,
				{27'h0, res[7], 1'b0, res == 8'h00, 1'b0, v[7]});
		end
		// returns with and without shadow restore
		p0 = $urandom & 32'h1fffff;
		p1 = $urandom & 32'h1fffff;
		w = $urandom & 32'hff;
		fl = $urandom & 32'h15;
		b = $urandom & 32'hf;
		ws = $urandom & 32'hff;
		fs = $urandom & 32'h15;
		bs = $urandom & 32'hf;
		lu = $urandom & 32'h1f;
		lh = $urandom & 32'hff;
		stk.push_back(p0);
		stk.push_back(p1);
		wr_ok(`SRRC_ADDR_STACK, p0);
		wr_ok(`SRRC_ADDR_STACK, p1);
		wr_ok(`SRRC_ADDR_WREG, w);
		wr_ok(`SRRC_ADDR_FLAGS, fl);
		wr_ok(`SRRC_ADDR_BSR, b);
		wr_ok(`SRRC_ADDR_WSHD, ws);
		wr_ok(`SRRC_ADDR_FSHD, fs);
		wr_ok(`SRRC_ADDR_BSHD, bs);
		wr_ok(`SRRC_ADDR_LATU, lu);
		wr_ok(`SRRC_ADDR_LATH, lh);
		run(`SRRC_OP_RET);
		rd_chk("return counter", `SRRC_ADDR_PC, stk.pop_back());
		rd_chk("return stack top", `SRRC_ADDR_STACK, stk[$]);
		rd_chk("plain return working", `SRRC_ADDR_WREG, w);
		rd_chk("plain return flags", `SRRC_ADDR_FLAGS, fl);
		rd_chk("plain return bank", `SRRC_ADDR_BSR, b);
		rd_chk("plain return upper latch", `SRRC_ADDR_LATU, lu);
		rd_chk("plain return high latch", `SRRC_ADDR_LATH, lh);
		run(`SRRC_OP_RET | 16'h0001);
		rd_chk("shadow return counter", `SRRC_ADDR_PC, stk.pop_back());
		rd_chk("shadow return working", `SRRC_ADDR_WREG, ws);
		rd_chk("shadow return flags", `SRRC_ADDR_FLAGS, fs);
		rd_chk("shadow return bank", `SRRC_ADDR_BSR, bs);
		rd_chk("shadow return upper latch", `SRRC_ADDR_LATU, lu);
		rd_chk("shadow return high latch", `SRRC_ADDR_LATH, lh);
		rd_chk("empty stack top", `SRRC_ADDR_STACK, 32'h0);
		// a latch write while the return runs must be refused
		wr_ok(`SRRC_ADDR_INSTR, {16'h0, `SRRC_OP_RET});
		apb(1'b1, `SRRC_ADDR_LATU, lu ^ 32'hff);
		chk("busy write error", {31'h0, er}, 32'h1);
		settle();
		rd_chk("empty pop counter", `SRRC_ADDR_PC, 32'h0);
		rd_chk("refused latch write", `SRRC_ADDR_LATU, lu);
		give_verdict();
	end
endmodule
`default_nettype wire
